// >>> hdl/rfb_defs.svh
// Offsets, field positions and reset values of the receive registers.
// Assumes the includer uses the paged address layout {page, 1'b0, offset}.
`ifndef RFB_DEFS_SVH
`define RFB_DEFS_SVH

// ==========================================================
// Address layout
`define RFB_ADDR_W        8
`define RFB_PAGE_MSB      7
`define RFB_PAGE_LSB      6
`define RFB_OFF_MSB       4
`define RFB_PAGE0         2'h0
`define RFB_PAGE2         2'h2

// ==========================================================
// Register offsets
`define RFB_OFF_RING_BEGIN 5'h11
`define RFB_OFF_DESCR_END  5'h12
`define RFB_OFF_NEXT_BUF   5'h15
`define RFB_OFF_PAIR_LO    5'h18
`define RFB_OFF_PAIR_HI    5'h19
`define RFB_OFF_CNT_LO     5'h1A
`define RFB_OFF_CNT_HI     5'h1B
`define RFB_OFF_CONFIG     5'h1C
`define RFB_OFF_MISSED     5'h1F

// ==========================================================
// Receive configuration field positions
`define RFB_CFG_ABORT_COL  6
`define RFB_CFG_CHECK_ONLY 5
`define RFB_CFG_ANY_UCAST  4
`define RFB_CFG_MCAST      3
`define RFB_CFG_ALL_ONES   2
`define RFB_CFG_SHORT      1
`define RFB_CFG_KEEP_ERR   0

// ==========================================================
// Reset values and limits
`define RFB_CFG_RESET      7'h00
`define RFB_MISSED_RESET   8'h00
`define RFB_MISSED_MAX     8'hFF
`define RFB_CNT_RESET      16'h0000
`define RFB_BYTE_ZERO      8'h00

`endif

// >>> hdl/rfb_pkg.sv
// Types shared by the receive filter and buffer register block.
// Assumes no macros; types only.
package rfb_pkg;

   // ==========================================================
   // Receive sequencing
   typedef enum logic [1:0] {RFB_IDLE, RFB_RECV, RFB_ABORTED} rfb_rx_state_t;

   // Status of a finished frame
   typedef struct packed {
      logic station_match;
      logic dest_group;
      logic dest_all_ones;
      logic hash_hit;
      logic short_frame;
      logic crc_err;
      logic align_err;
      logic fifo_overflow;
      logic no_buffers;
   } rfb_frame_info_t;

   // Working register updates from the receive DMA
   typedef struct packed {
      logic        next_we;
      logic [7:0]  next_val;
      logic        burst_we;
      logic [15:0] burst_val;
      logic        room_we;
      logic [15:0] room_val;
   } rfb_dma_upd_t;

   // Pointer view handed to the receive DMA
   typedef struct packed {
      logic [7:0]  ring_start;
      logic [7:0]  descr_begin;
      logic [7:0]  descr_end;
      logic [7:0]  next_buf;
      logic [15:0] burst;
      logic [15:0] room;
   } rfb_dma_view_t;

   // One-cycle verdict pulses per frame
   typedef struct packed {
      logic store;
      logic discard;
      logic abort;
      logic missed;
      logic fault_set;
   } rfb_verdict_t;

   // Whole block state
   typedef struct packed {
      rfb_rx_state_t fsm;
      logic          col_meta;
      logic          col_sync;
      logic          prev_pre_zero;
      logic          pre_bad;
      logic [6:0]    cfg;
      logic [7:0]    missed;
      logic [15:0]   byte_cnt;
      rfb_dma_view_t dma;
      logic [7:0]    rd_data;
      rfb_verdict_t  verdict;
      logic          check_only_active;
   } rfb_state_t;

endpackage

// >>> hdl/rfb_regs.sv
// Receive filter, missed-packet counter, byte count and receive DMA pointer registers.
// Assumes a same-clock receive front end, DMA engine and paged host register port.
//
// Notes on behaviour
// - Missed count rises on no buffers, FIFO overflow or check-only mode.
// - Only frames with a recognised destination can advance the missed counter.
// - Missed counter is 8 bits, resets to zero, sticks at its maximum.
// - Reading the missed counter returns its value and clears it.
// - DMA keeps high address byte of the next buffer to open.
// - DMA keeps a 16-bit burst address pair, host readable and writable.
// - Descriptor table begin gives address bits 15..8, low byte zero.
// - 16-bit received byte count in two bytes, cleared at reception start.
// - Config bits 6..0 as assigned, bit 7 reads zero, all reset to zero.
// - Config options act independently; check-only mode overrides keep-errored, while abort-on-collision overrides check-only.
// - Abort-on-collision drops frames with collision after start delimiter, despite keep-errors.
// - Abort-on-collision also drops frames with consecutive zero preamble bits.
// - Frames aborted by abort-on-collision never raise the receive fault flag.
// - Check-only mode checks address and length, stores nothing, counts recognised frames missed.
// - Accept-any-unicast takes every individual destination frame.
// - Accept-multicast takes group frames only when the hash filter hits.
// - Accept-all-ones takes every broadcast frame.
// - Short frames are taken only with accept-short set.
// - Keep-errored stores CRC or alignment error frames instead of discarding.
// - DMA keeps 16-bit buffer room remaining; host must not write it in traffic.
// - Descriptor table spans begin*256 up to end*256 minus one.
// - Ring start gives address bits 15..8; buffers align to 256-byte pages.
// - Multicast hash table lives in eight byte registers of the hash unit.
`timescale 1ns/1ps
`include "rfb_defs.svh"

module rfb_regs
(
   // Clock and reset
   input  wire logic                     ref_clk,
   input  wire logic                     reset,
   // Host register port
   input  wire logic [`RFB_ADDR_W-1:0]   reg_addr,
   input  wire logic [7:0]               reg_wdata,
   input  wire logic                     reg_wr,
   input  wire logic                     reg_rd,
   output logic [7:0]                    reg_rdata,
   // Map selection
   input  wire logic                     linked_list_map,
   // Receive front end
   input  wire logic                     rx_col_pin,
   input  wire logic                     pre_bit_valid,
   input  wire logic                     pre_bit,
   input  wire logic                     sfd_seen,
   input  wire logic                     byte_valid,
   input  wire logic                     frame_end,
   input  wire rfb_pkg::rfb_frame_info_t frame_info,
   // Receive DMA
   input  wire rfb_pkg::rfb_dma_upd_t    dma_upd,
   output rfb_pkg::rfb_dma_view_t        dma_view,
   // Verdicts and status
   output rfb_pkg::rfb_verdict_t         verdict,
   output logic [6:0]                    rx_config_bits,
   output logic                          check_only_active
);
   import rfb_pkg::*;

   // ==========================================================
   // Helper functions

   // Page and offset match of the host address
   function automatic logic addr_hit(input logic [`RFB_ADDR_W-1:0] a,
                                     input logic [1:0]             page,
                                     input logic [4:0]             off);
      addr_hit = (a[`RFB_PAGE_MSB:`RFB_PAGE_LSB] == page) && (a[`RFB_OFF_MSB:0] == off);
   endfunction

   // Saturating increment; sticks rather than wraps
   function automatic logic [7:0] sat_inc(input logic [7:0] v);
      if (v == `RFB_MISSED_MAX)
      begin
         sat_inc = v;
      end
      else
      begin
         sat_inc = v + 8'h01;
      end
   endfunction

   // ==========================================================
   // State
   rfb_state_t st;
   rfb_state_t next_st;

   // Decode and verdict terms
   logic       wr_p0;
   logic       wr_p2;
   logic       rd_p0;
   logic       rd_p2;
   logic       missed_read;
   logic       is_individual;
   logic       recognized;
   logic       length_ok;
   logic       has_err;
   logic       abort_col;
   logic       frame_missed;
   logic [7:0] rd_value;

   // ==========================================================
   // Outputs straight from the state flops
   assign reg_rdata         = st.rd_data;
   assign dma_view          = st.dma;
   assign verdict           = st.verdict;
   assign rx_config_bits    = st.cfg;
   assign check_only_active = st.check_only_active;

   // Page qualifiers of the host strobes
   assign wr_p0 = reg_wr && (reg_addr[`RFB_PAGE_MSB:`RFB_PAGE_LSB] == `RFB_PAGE0);
   assign wr_p2 = reg_wr && (reg_addr[`RFB_PAGE_MSB:`RFB_PAGE_LSB] == `RFB_PAGE2);
   assign rd_p0 = reg_rd && (reg_addr[`RFB_PAGE_MSB:`RFB_PAGE_LSB] == `RFB_PAGE0);
   assign rd_p2 = reg_rd && (reg_addr[`RFB_PAGE_MSB:`RFB_PAGE_LSB] == `RFB_PAGE2);

   assign missed_read = reg_rd && addr_hit(reg_addr, `RFB_PAGE0, `RFB_OFF_MISSED);

   // ==========================================================
   // Address recognition of a finished frame
   assign is_individual = !frame_info.dest_group;
   assign recognized = frame_info.station_match
      || (st.cfg[`RFB_CFG_ANY_UCAST] && is_individual)
      || (st.cfg[`RFB_CFG_MCAST] && frame_info.dest_group
          && !frame_info.dest_all_ones && frame_info.hash_hit)
      || (st.cfg[`RFB_CFG_ALL_ONES] && frame_info.dest_all_ones);

   // Runts pass only when asked for
   assign length_ok = !frame_info.short_frame || st.cfg[`RFB_CFG_SHORT];
   assign has_err   = frame_info.crc_err || frame_info.align_err;

   // Collision seen after the delimiter, on the synchronised level only
   assign abort_col = st.cfg[`RFB_CFG_ABORT_COL] && st.col_sync;

   // Recognised frame that could not be taken
   assign frame_missed = recognized && length_ok
      && (st.cfg[`RFB_CFG_CHECK_ONLY]
          || frame_info.no_buffers || frame_info.fifo_overflow);

   // ==========================================================
   // Read multiplexer; unmapped addresses answer zero
   always_comb
   begin
      rd_value = `RFB_BYTE_ZERO;
      if (rd_p0)
      begin
         case (reg_addr[`RFB_OFF_MSB:0])
            `RFB_OFF_MISSED: rd_value = st.missed;
            `RFB_OFF_CNT_LO: rd_value = st.byte_cnt[7:0];
            `RFB_OFF_CNT_HI: rd_value = st.byte_cnt[15:8];
            default:         rd_value = `RFB_BYTE_ZERO;
         endcase
      end
      else if (rd_p2)
      begin
         case (reg_addr[`RFB_OFF_MSB:0])
            `RFB_OFF_CONFIG:     rd_value = {1'b0, st.cfg};
            `RFB_OFF_RING_BEGIN: rd_value = linked_list_map ? st.dma.descr_begin
                                                            : st.dma.ring_start;
            `RFB_OFF_DESCR_END:  rd_value = linked_list_map ? st.dma.descr_end
                                                            : `RFB_BYTE_ZERO;
            `RFB_OFF_NEXT_BUF:   rd_value = linked_list_map ? `RFB_BYTE_ZERO
                                                            : st.dma.next_buf;
            `RFB_OFF_PAIR_LO:    rd_value = linked_list_map ? st.dma.room[7:0]
                                                            : st.dma.burst[7:0];
            `RFB_OFF_PAIR_HI:    rd_value = linked_list_map ? st.dma.room[15:8]
                                                            : st.dma.burst[15:8];
            default:             rd_value = `RFB_BYTE_ZERO;
         endcase
      end
   end

   // ==========================================================
   // Next-state logic for the whole block
   always_comb
   begin
      next_st = st;

      // Read data stand for one cycle only
      next_st.rd_data = rd_value;

      // Verdict outputs are single-cycle pulses
      next_st.verdict = '0;

      // Collision pin is asynchronous; the first stage feeds only the second
      next_st.col_meta = rx_col_pin;
      next_st.col_sync = st.col_meta;

      // Check-only status follows the config bit
      next_st.check_only_active = st.cfg[`RFB_CFG_CHECK_ONLY];

      // Host writes to page 0
      if (wr_p0)
      begin
         case (reg_addr[`RFB_OFF_MSB:0])
            `RFB_OFF_CONFIG:
               next_st.cfg = reg_wdata[6:0];
            `RFB_OFF_RING_BEGIN:
               if (linked_list_map)
               begin
                  next_st.dma.descr_begin = reg_wdata;
               end
               else
               begin
                  next_st.dma.ring_start = reg_wdata;
               end
            `RFB_OFF_DESCR_END:
               if (linked_list_map)
               begin
                  next_st.dma.descr_end = reg_wdata;
               end
            default:
               next_st.cfg = st.cfg;
         endcase
      end

      // Host writes to page 2; the pair in use depends on the map
      if (wr_p2)
      begin
         case (reg_addr[`RFB_OFF_MSB:0])
            `RFB_OFF_NEXT_BUF:
               if (!linked_list_map)
               begin
                  next_st.dma.next_buf = reg_wdata;
               end
            `RFB_OFF_PAIR_LO:
               if (linked_list_map)
               begin
                  next_st.dma.room[7:0] = reg_wdata;
               end
               else
               begin
                  next_st.dma.burst[7:0] = reg_wdata;
               end
            `RFB_OFF_PAIR_HI:
               if (linked_list_map)
               begin
                  next_st.dma.room[15:8] = reg_wdata;
               end
               else
               begin
                  next_st.dma.burst[15:8] = reg_wdata;
               end
            default:
               next_st.cfg = st.cfg;
         endcase
      end

      // DMA update beats a same-cycle host write;
      // writing during traffic is the host's fault
      if (dma_upd.next_we)
      begin
         next_st.dma.next_buf = dma_upd.next_val;
      end
      if (dma_upd.burst_we)
      begin
         next_st.dma.burst = dma_upd.burst_val;
      end
      if (dma_upd.room_we)
      begin
         next_st.dma.room = dma_upd.room_val;
      end

      // Clear on read; an increment in the same cycle lands below
      if (missed_read)
      begin
         next_st.missed = `RFB_MISSED_RESET;
      end

      // Receive sequencing
      case (st.fsm)
         RFB_IDLE:
         begin
            // Watch the preamble for two zero bits in a row
            if (pre_bit_valid)
            begin
               next_st.prev_pre_zero = !pre_bit;
               if (!pre_bit && st.prev_pre_zero)
               begin
                  next_st.pre_bad = 1'b1;
               end
            end
            if (sfd_seen)
            begin
               next_st.byte_cnt      = `RFB_CNT_RESET;
               next_st.prev_pre_zero = 1'b0;
               next_st.pre_bad       = 1'b0;
               if (st.cfg[`RFB_CFG_ABORT_COL] && st.pre_bad)
               begin
                  // Bad preamble: drop quietly, no fault flag
                  next_st.verdict.abort = 1'b1;
                  next_st.fsm           = RFB_ABORTED;
               end
               else
               begin
                  next_st.fsm = RFB_RECV;
               end
            end
         end

         RFB_RECV:
         begin
            if (byte_valid)
            begin
               next_st.byte_cnt = st.byte_cnt + 16'h0001;
            end
            if (abort_col)
            begin
               // Keep-errored does not rescue a collided frame
               next_st.verdict.abort = 1'b1;
               next_st.fsm           = frame_end ? RFB_IDLE : RFB_ABORTED;
            end
            else if (frame_end)
            begin
               next_st.fsm = RFB_IDLE;
               if (st.cfg[`RFB_CFG_CHECK_ONLY])
               begin
                  // Checked only, never stored
                  next_st.verdict.discard   = 1'b1;
                  next_st.verdict.missed    = frame_missed;
                  next_st.verdict.fault_set = frame_missed;
               end
               else if (!recognized || !length_ok)
               begin
                  next_st.verdict.discard = 1'b1;
               end
               else if (frame_missed)
               begin
                  // Buffer shortage raises no fault; overflow without buffer shortage does
                  next_st.verdict.discard   = 1'b1;
                  next_st.verdict.missed    = 1'b1;
                  next_st.verdict.fault_set = frame_info.fifo_overflow
                                              && !frame_info.no_buffers;
               end
               else if (has_err && !st.cfg[`RFB_CFG_KEEP_ERR])
               begin
                  next_st.verdict.discard = 1'b1;
               end
               else
               begin
                  next_st.verdict.store     = 1'b1;
                  next_st.verdict.fault_set = has_err;
               end
               if (frame_missed)
               begin
                  next_st.missed = sat_inc(missed_read ? `RFB_MISSED_RESET
                                                       : st.missed);
               end
            end
         end

         RFB_ABORTED:
         begin
            // Wait out the rest of the dropped frame
            if (frame_end)
            begin
               next_st.fsm = RFB_IDLE;
            end
         end

         default:
            next_st.fsm = RFB_IDLE;
      endcase
   end

   // ==========================================================
   // State register; pointers reset to zero
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         st        <= '0;
         st.fsm    <= RFB_IDLE;
         st.cfg    <= `RFB_CFG_RESET;
         st.missed <= `RFB_MISSED_RESET;
      end
      else
      begin
         st <= next_st;
      end
   end

endmodule

// >>> bench/rfb_regs_asserts.sv
// Concurrent checks on the receive filter and buffer register block.
// Assumes binding to rfb_regs; sees only its ports.
`timescale 1ns/1ps

module rfb_regs_asserts
(
   // Clock, reset and host port
   input wire logic                     ref_clk,
   input wire logic                     reset,
   input wire logic [7:0]               reg_addr,
   input wire logic [7:0]               reg_wdata,
   input wire logic                     reg_wr,
   input wire logic                     reg_rd,
   input wire logic [7:0]               reg_rdata,
   // Receive and DMA side
   input wire logic                     frame_end,
   input wire rfb_pkg::rfb_frame_info_t frame_info,
   input wire rfb_pkg::rfb_dma_upd_t    dma_upd,
   input wire rfb_pkg::rfb_dma_view_t   dma_view,
   input wire rfb_pkg::rfb_verdict_t    verdict,
   input wire logic [6:0]               rx_config_bits,
   input wire logic                     check_only_active
);
   import rfb_pkg::*;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   // ==========================================================
   // Decodes; address bit 5 is unused
   wire cfg_wr = reg_wr && reg_addr[7:6] == 2'h0 && reg_addr[4:0] == 5'h1C;
   wire cfg_rd = reg_rd && reg_addr[4:0] == 5'h1C;
   wire plain  = rx_config_bits[6:5] == 2'h0 && !check_only_active;
   wire clean  = frame_info.station_match && frame_info[4:0] == 5'h00;
   chk_cfg_write: assert property (cfg_wr |=> rx_config_bits == $past(reg_wdata[6:0]))
      else $error("config differs from write");
   chk_top_zero: assert property (cfg_rd |=> !reg_rdata[7])
      else $error("config bit 7 read as one");
   chk_check_follow: assert property ($rose(rx_config_bits[5]) |=> check_only_active)
      else $error("check-only not taken");
   chk_abort_quiet: assert property (verdict.abort
      |-> !verdict.fault_set && !verdict.missed)
      else $error("abort raised fault or miss");
   chk_missed_cause: assert property (verdict.missed |-> $past(frame_end))
      else $error("miss without frame end");
   chk_check_nostore: assert property (frame_end && check_only_active
      |=> !verdict.store)
      else $error("stored in check-only");
   chk_short_drop: assert property (frame_end && frame_info.short_frame
      && !rx_config_bits[1] |=> !verdict.store && !verdict.missed)
      else $error("short frame taken");
   chk_err_drop: assert property (frame_end && !rx_config_bits[0]
      && (frame_info.crc_err || frame_info.align_err) |=> !verdict.store)
      else $error("errored frame stored");
   chk_station_take: assert property (frame_end && plain && clean |=> verdict.store)
      else $error("station frame not stored");
   chk_unrec_quiet: assert property (frame_end && !frame_info.station_match
      && rx_config_bits[4:2] == 3'h0 |=> !verdict.missed && !verdict.store)
      else $error("unrecognised frame taken");
   chk_next_buf: assert property (dma_upd.next_we
      |=> dma_view.next_buf == $past(dma_upd.next_val))
      else $error("next buffer not updated");
   chk_room_left: assert property (dma_upd.room_we
      |=> dma_view.room == $past(dma_upd.room_val))
      else $error("room left not updated");
endmodule

bind rfb_regs rfb_regs_asserts rfb_regs_asserts_inst (.ref_clk, .reset, .reg_addr, .reg_wdata,
   .reg_wr, .reg_rd, .reg_rdata, .frame_end, .frame_info, .dma_upd, .dma_view, .verdict,
   .rx_config_bits, .check_only_active);

// >>> bench/rfb_net_model.sv
// Network front end model: preamble, delimiter, bytes, collision and frame status.
// Assumes the bench calls send between frames on the same clock.
`timescale 1ns/1ps

module rfb_net_model
(
   // Clock
   input  wire logic                ref_clk,
   // Receive front end lines
   output logic                     rx_col_pin,
   output logic                     pre_bit_valid,
   output logic                     pre_bit,
   output logic                     sfd_seen,
   output logic                     byte_valid,
   output logic                     frame_end,
   output rfb_pkg::rfb_frame_info_t frame_info
);
   import rfb_pkg::*;
   // Quiet line at start
   initial
   begin
      {rx_col_pin, pre_bit_valid, pre_bit, sfd_seen, byte_valid, frame_end} = 6'h00;
      frame_info = '1;
   end
   // One frame; bad preamble is all zeros, collision rises after byte one
   task automatic send(input int n, input rfb_frame_info_t fi, input bit col, input bit bad);
      for (int i = 0; i < 8; i++)
      begin
         @(posedge ref_clk);
         pre_bit_valid <= 1'b1;
         pre_bit       <= bad ? 1'b0 : i[0];
      end
      @(posedge ref_clk);
      pre_bit_valid <= 1'b0;
      sfd_seen      <= 1'b1;
      for (int i = 0; i < n; i++)
      begin
         @(posedge ref_clk);
         sfd_seen   <= 1'b0;
         byte_valid <= 1'b1;
         rx_col_pin <= col && i > 0;
      end
      @(posedge ref_clk);
      byte_valid <= 1'b0;
      frame_end  <= 1'b1;
      frame_info <= fi;
      @(posedge ref_clk);
      frame_end  <= 1'b0;
      rx_col_pin <= 1'b0;
      frame_info <= ~fi; // Stale status never looks like the last frame
   endtask
endmodule

// >>> bench/tb.sv
// Self-checking bench for the receive filter and buffer register block.
// Assumes rfb_regs, its checker and the network model are compiled first.
`timescale 1ns/1ps

module tb;
   import rfb_pkg::*;
   // ==========================================================
   // Signals; address top two bits are the page
   logic            ref_clk, reset, reg_wr, reg_rd, linked_list_map, clr;
   logic [7:0]      reg_addr, reg_wdata, reg_rdata;
   logic            rx_col_pin, pre_bit_valid, pre_bit, sfd_seen, byte_valid, frame_end;
   rfb_frame_info_t frame_info, f;
   rfb_dma_upd_t    dma_upd;
   rfb_dma_view_t   dma_view;
   rfb_verdict_t    verdict, seen;
   logic [6:0]      rx_config_bits, c;
   logic            check_only_active;
   int              fail_count, compares, mc, i;
   logic [31:0]     rs;
   logic [7:0]      wa [6] = '{8'h11, 8'h95, 8'h98, 8'h11, 8'h12, 8'h99};
   logic [7:0]      ra [6] = '{8'h91, 8'h95, 8'h98, 8'h91, 8'h92, 8'h99};

   rfb_regs rfb_regs_inst (.ref_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .linked_list_map, .rx_col_pin, .pre_bit_valid, .pre_bit, .sfd_seen,
      .byte_valid, .frame_end, .frame_info, .dma_upd, .dma_view, .verdict, .rx_config_bits,
      .check_only_active);
   rfb_net_model rfb_net_model_inst (.ref_clk, .rx_col_pin, .pre_bit_valid, .pre_bit,
      .sfd_seen, .byte_valid, .frame_end, .frame_info);

   // ==========================================================
   // Clock; verdicts gather until cleared
   initial
   begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) seen <= clr ? '0 : seen | verdict;

   // ==========================================================
   // Helpers and reference model
   function automatic logic [31:0] xs(input logic [31:0] v);
      v = v ^ (v << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction
   // Verdict as {store, discard, abort, missed, fault}
   function automatic logic [4:0] model(input logic [6:0] k, input rfb_frame_info_t x);
      logic rec, lok, ms;
      rec = x.station_match | (k[4] & !x.dest_group) | (k[2] & x.dest_all_ones)
          | (k[3] & x.dest_group & !x.dest_all_ones & x.hash_hit);
      lok = !x.short_frame | k[1];
      ms  = rec & lok & (k[5] | x.no_buffers | x.fifo_overflow);
      if (k[5]) return {3'b010, ms, ms};
      if (!rec || !lok) return 5'b01000;
      if (ms) return {4'b0101, x.fifo_overflow & !x.no_buffers};
      if ((x.crc_err | x.align_err) & !k[0]) return 5'b01000;
      return {4'b1000, x.crc_err | x.align_err};
   endfunction
   task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
      compares++;
      if (s !== e)
      begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] ad, input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= ad;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr    <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rdc(input logic [7:0] ad, input logic [7:0] e, input string nm);
      @(posedge ref_clk);
      reg_rd   <= 1'b1;
      reg_addr <= ad;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 chk(nm, reg_rdata, e);
   endtask
   task automatic frm(input int n, input rfb_frame_info_t x, input bit col, input bit bad,
                      input logic [4:0] e);
      @(posedge ref_clk);
      clr <= 1'b1;
      @(posedge ref_clk);
      clr <= 1'b0;
      rfb_net_model_inst.send(n, x, col, bad);
      repeat (2) @(posedge ref_clk);
      #1 chk("verdict", seen, e);
      if (e[1]) mc = (mc < 255) ? mc + 1 : 255;
      if (!e[2]) rdc(8'h1A, n[7:0], "rx_byte_count_lo");
      if (!e[2]) rdc(8'h1B, n[15:8], "rx_byte_count_hi");
   endtask
   task automatic summarize();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // ==========================================================
   // Watchdog: a hang counts as a mismatch
   initial
   begin
      repeat (90000) @(posedge ref_clk);
      fail_count++;
      summarize();
   end

   // ==========================================================
   // Main sequence
   initial
   begin
      {reset, reg_wr, reg_rd, linked_list_map, clr} = 5'h10;
      {reg_addr, reg_wdata, dma_upd} = '0;
      {fail_count, compares, mc} = '0;
      rs = 32'hB22E;
      repeat (2) @(posedge ref_clk);
      reset <= 1'b0;
      rdc(8'h9C, 8'h00, "rx_config");
      rdc(8'h1F, 8'h00, "missed_packet_count");
      wr(8'h1C, 8'hFF);
      rdc(8'h9C, 8'h7F, "rx_config");
      rdc(8'hC5, 8'h00, "unmapped");
      // Random options and status; check-only one time in four
      for (i = 0; i < 200; i++)
      begin
         rs = xs(rs);
         c  = rs[6:0] & {1'b1, rs[8], 5'h1F};
         f  = rs[25:17];
         wr(8'h1C, {1'b0, c});
         frm(1 + rs[12:9], f, 1'b0, 1'b0, model(c, f));
         rdc(8'h1F, mc[7:0], "missed_packet_count");
         mc = 0;
      end
      // Counter sticks at top, clears on read
      wr(8'h1C, 8'h20);
      f = 9'h100;
      for (i = 0; i < 257; i++) frm(1, f, 1'b0, 1'b0, 5'b01011);
      rdc(8'h1F, 8'hFF, "missed_packet_count");
      rdc(8'h1F, 8'h00, "missed_packet_count");
      // Quiet aborts despite keep-errored, then a long good frame
      wr(8'h1C, 8'h41);
      frm(8, f, 1'b1, 1'b0, 5'b00100);
      frm(8, f, 1'b0, 1'b1, 5'b00100);
      frm(300, f, 1'b0, 1'b0, 5'b10000);
      // Pointers in both maps, written only with no traffic
      for (i = 0; i < 6; i++)
      begin
         rs = xs(rs);
         @(posedge ref_clk);
         linked_list_map <= (i > 2);
         wr(wa[i], rs[7:0]);
         rdc(ra[i], rs[7:0], "pointer");
      end
      @(posedge ref_clk);
      dma_upd <= '{1'b1, 8'h5A, 1'b1, 16'h7E24, 1'b1, 16'hC3E1};
      @(posedge ref_clk);
      dma_upd <= '0;
      #1 chk("next_buf", dma_view.next_buf, 8'h5A);
      chk("burst", dma_view.burst, 16'h7E24);
      rdc(8'h98, 8'hE1, "rx_room_left_lo");
      summarize();
   end
endmodule
